// *** rtl/slice_cc_defines.vh ***
// Constants for the timer slice compare, timer and capture register set.
// Included by the slice register module; holds definitions only.
`ifndef SLICE_CC_DEFINES_VH
`define SLICE_CC_DEFINES_VH

// Register byte addresses
`define OFS_COMPARE_SHADOW    8'h00
`define OFS_TIMER_COUNT       8'h04
`define OFS_CAPTURE_ZERO      8'h08
`define OFS_CAPTURE_ONE       8'h0C
`define OFS_CAPTURE_TWO       8'h10
`define OFS_ACTIVE_COMPARE    8'h14
`define OFS_INT_STATUS        8'h18
`define OFS_INT_MASK          8'h1C

// Address width and capture register spacing
`define ADDR_W                8
`define CAPTURE_STRIDE        8'h04
`define NUM_CAPTURE           3

// Capture register field positions
`define CAPT_VALUE_MSB        15
`define CAPT_VALUE_LSB        0
`define CAPT_PRESC_MSB        19
`define CAPT_PRESC_LSB        16
`define CAPT_FULL_BIT         20

// Interrupt status layout: bits 2..0 capture events, bit 3 shadow transfer
`define INT_W                 4
`define INT_SHADOW_BIT        3

// Reset values
`define RST_COMPARE_SHADOW    16'h0000
`define RST_ACTIVE_COMPARE    16'h0000
`define RST_CAPTURE_VALUE     16'h0000
`define RST_CAPTURE_PRESC     4'h0
`define RST_INT_MASK          4'h0

`endif

// *** rtl/slice_cc_regs.v ***
// Compare shadow, timer count and capture registers of one timer slice.
// Assumes one clock; counter, prescaler and shadow transfer logic sit outside
// and all their signals are synchronous to clk.
//
// Overview of operation
// - A 16-bit compare shadow value is held and copied into the active compare value on each shadow transfer.
// - In capture mode with an external signal capturing into capture registers zero and one, the shadow reads zero.
// - The running timer count can be read, and a software write to it is accepted only while the timer is stopped.
// - Bits 31 to 16 of shadow and timer registers and bits 31 to 21 of each capture register read as zero.
// - Each of the three capture registers keeps its captured 16-bit timer value in bits 15 to 0.
// - Each capture also stores the 4-bit prescaler value of that moment in bits 19 to 16.
// - Bit 20 of each capture register is a full flag, one when a value was captured since the last read.
// - In compare mode every read of a capture register returns zero in all fields.
// - The active compare value cannot be written by software and changes only by shadow transfer.
`timescale 1ns/1ps
`include "slice_cc_defines.vh"

module slice_cc_regs (
	// Clock and reset
	input  wire                     clk,
	input  wire                     rst_n,
	// Register port
	input  wire [`ADDR_W-1:0]       reg_addr,
	input  wire [31:0]              reg_wdata,
	input  wire                     reg_wr,
	input  wire                     reg_rd,
	output reg  [31:0]              reg_rdata,
	// Slice mode and timer state
	input  wire                     compare_mode,
	input  wire                     capture_ext_01,
	input  wire                     timer_running,
	input  wire [15:0]              timer_count_value,
	input  wire [3:0]               prescaler_value,
	// Events from the slice
	input  wire                     shadow_transfer,
	input  wire [`NUM_CAPTURE-1:0]  capture_event,
	// Outputs to the slice
	output reg  [15:0]              active_compare_value,
	output reg                      timer_load,
	output reg  [15:0]              timer_load_value,
	output wire                     irq
);

	// Register selects
	wire                     sel_shadow;
	wire                     sel_timer;
	wire                     sel_active;
	wire                     sel_status;
	wire                     sel_mask;
	wire [`NUM_CAPTURE-1:0]  sel_capture;

	// Stored state
	reg  [15:0]              compare_shadow_q;
	reg  [15:0]              compare_shadow_d;
	reg  [15:0]              active_compare_d;
	reg  [`INT_W-1:0]        int_status_q;
	reg  [`INT_W-1:0]        int_status_d;
	reg  [`INT_W-1:0]        int_mask_q;
	reg  [`INT_W-1:0]        int_mask_d;
	reg  [31:0]              rdata_d;
	reg                      timer_load_d;
	reg  [15:0]              timer_load_value_d;

	// Per-capture read words, zero unless that register is addressed in capture mode
	wire [31:0]              capt_rd_word [0:`NUM_CAPTURE-1];
	reg  [31:0]              capt_rd_any;
	integer                  ci;
	wire [`NUM_CAPTURE-1:0]  capt_taken;

	// Events raised this cycle
	wire [`INT_W-1:0]        int_events;

	assign sel_shadow = (reg_addr == `OFS_COMPARE_SHADOW);
	assign sel_timer  = (reg_addr == `OFS_TIMER_COUNT);
	assign sel_active = (reg_addr == `OFS_ACTIVE_COMPARE);
	assign sel_status = (reg_addr == `OFS_INT_STATUS);
	assign sel_mask   = (reg_addr == `OFS_INT_MASK);

	// Captures are only taken while the slice is in capture mode
	assign capt_taken = compare_mode ? {`NUM_CAPTURE{1'b0}} : capture_event;

	assign int_events = {shadow_transfer, capt_taken};

	// Capture registers, one per generate entry
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CAPTURE; gi = gi + 1) begin : g_capt
			reg  [15:0] value_q;
			reg  [15:0] value_d;
			reg  [3:0]  presc_q;
			reg  [3:0]  presc_d;
			reg         full_q;
			reg         full_d;
			wire        rd_hit;

			assign sel_capture[gi] = (reg_addr == (`OFS_CAPTURE_ZERO + gi * `CAPTURE_STRIDE));
			assign rd_hit          = reg_rd & sel_capture[gi];

			always @* begin
				value_d = value_q;
				presc_d = presc_q;
				full_d  = full_q;
				if (rd_hit) begin
					full_d = 1'b0;
				end
				if (capt_taken[gi]) begin
					value_d = timer_count_value;
					presc_d = prescaler_value;
					full_d  = 1'b1;
				end
			end

			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					value_q <= `RST_CAPTURE_VALUE;
					presc_q <= `RST_CAPTURE_PRESC;
					full_q  <= 1'b0;
				end else begin
					value_q <= value_d;
					presc_q <= presc_d;
					full_q  <= full_d;
				end
			end

			// Compare mode hides all capture fields
			assign capt_rd_word[gi] = (sel_capture[gi] && !compare_mode) ?
				{11'h000, full_q, presc_q, value_q} : 32'h0000_0000;
		end
	endgenerate

	// Compare shadow and active compare
	always @* begin
		compare_shadow_d = compare_shadow_q;
		active_compare_d = active_compare_value;
		if (reg_wr && sel_shadow) begin
			compare_shadow_d = reg_wdata[15:0];
		end
		if (shadow_transfer) begin
			active_compare_d = compare_shadow_q;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_shadow_q     <= `RST_COMPARE_SHADOW;
			active_compare_value <= `RST_ACTIVE_COMPARE;
		end else begin
			compare_shadow_q     <= compare_shadow_d;
			active_compare_value <= active_compare_d;
		end
	end

	// Timer count write, passed to the counter as a one-cycle load
	always @* begin
		timer_load_d       = 1'b0;
		timer_load_value_d = timer_load_value;
		if (reg_wr && sel_timer && !timer_running) begin
			timer_load_d       = 1'b1;
			timer_load_value_d = reg_wdata[15:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_load       <= 1'b0;
			timer_load_value <= 16'h0000;
		end else begin
			timer_load       <= timer_load_d;
			timer_load_value <= timer_load_value_d;
		end
	end

	// Interrupt status and mask; a set in the clearing cycle wins
	always @* begin
		int_status_d = int_status_q;
		int_mask_d   = int_mask_q;
		if (reg_rd && sel_status) begin
			int_status_d = {`INT_W{1'b0}};
		end
		int_status_d = int_status_d | int_events;
		if (reg_wr && sel_mask) begin
			int_mask_d = reg_wdata[`INT_W-1:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_status_q <= {`INT_W{1'b0}};
			int_mask_q   <= `RST_INT_MASK;
		end else begin
			int_status_q <= int_status_d;
			int_mask_q   <= int_mask_d;
		end
	end

	assign irq = |(int_status_q & int_mask_q);

	// Merge of the capture read words; at most one is selected
	always @* begin
		capt_rd_any = 32'h0000_0000;
		for (ci = 0; ci < `NUM_CAPTURE; ci = ci + 1) begin
			capt_rd_any = capt_rd_any | capt_rd_word[ci];
		end
	end

	// Read data, presented the cycle after the read strobe
	always @* begin
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			if (sel_shadow) begin
				if (!(compare_mode == 1'b0 && capture_ext_01)) begin
					rdata_d[15:0] = compare_shadow_q;
				end
			end else if (sel_timer) begin
				rdata_d[15:0] = timer_count_value;
			end else if (sel_active) begin
				rdata_d[15:0] = active_compare_value;
			end else if (sel_status) begin
				rdata_d[`INT_W-1:0] = int_status_q;
			end else if (sel_mask) begin
				rdata_d[`INT_W-1:0] = int_mask_q;
			end else begin
				rdata_d = capt_rd_any;
			end
			// Capture reads in compare mode and unmapped reads return zero
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= rdata_d;
		end
	end

endmodule

// *** dv/slice_cc_props.sv ***
// Checker for the slice compare, timer and capture registers.
// Assumes a bind onto slice_cc_regs; everything runs on clk.
`timescale 1ns/1ps
module slice_cc_props (
	// Clock, reset and register port
	input wire        clk, rst_n, reg_wr, reg_rd,
	input wire [7:0]  reg_addr,
	input wire [31:0] reg_wdata, reg_rdata,
	// Slice side
	input wire        compare_mode, capture_ext_01, timer_running, shadow_transfer, timer_load,
	input wire [15:0] timer_count_value, active_compare_value, timer_load_value,
	input wire [3:0]  prescaler_value,
	input wire [2:0]  capture_event
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire cap_rd = reg_rd && (reg_addr inside {8'h08, 8'h0C, 8'h10});
	property p_cr; $changed(active_compare_value) |-> $past(shadow_transfer); endproperty
	a_cr: assert property (p_cr) else $error("active compare moved");
	property p_hi; reg_rd && reg_addr < 8'h08 |=> reg_rdata[31:16] == 16'h0000; endproperty
	a_hi: assert property (p_hi) else $error("upper bits set");
	property p_cm; cap_rd && compare_mode |=> reg_rdata == 32'h00000000; endproperty
	a_cm: assert property (p_cm) else $error("capture read in compare mode");
	property p_sh; reg_rd && reg_addr == 8'h00 && !compare_mode && capture_ext_01 |=> reg_rdata == 32'h0; endproperty
	a_sh: assert property (p_sh) else $error("shadow visible");
	property p_tr; reg_wr && reg_addr == 8'h04 && timer_running |=> !timer_load; endproperty
	a_tr: assert property (p_tr) else $error("load while running");
	property p_tl; reg_wr && reg_addr == 8'h04 && !timer_running |=>
		timer_load && {16'h0000, timer_load_value} == ($past(reg_wdata) & 32'h0000FFFF); endproperty
	a_tl: assert property (p_tl) else $error("timer load wrong");
	property p_fc; reg_rd && reg_addr == 8'h08 && !capture_event[0] ##1 !capture_event[0]
		##1 reg_rd && reg_addr == 8'h08 && !compare_mode |=> !reg_rdata[20]; endproperty
	a_fc: assert property (p_fc) else $error("full flag stuck");
	property p_cf; capture_event[1] && !compare_mode ##1 !capture_event[1] ##1 reg_rd && reg_addr == 8'h0C
		&& !compare_mode |=> reg_rdata[20:0] == {1'b1, $past(prescaler_value, 3), $past(timer_count_value, 3)};
	endproperty
	a_cf: assert property (p_cf) else $error("capture fields wrong");
endmodule
bind slice_cc_regs slice_cc_props u_slice_cc_props (.*);

// *** dv/timer_slice_compare_capture_regs_bench.sv ***
// Self-checking bench for the slice compare, timer and capture registers.
// Assumes slice_cc_regs with its checker bound in; one 40 MHz clock.
`timescale 1ns/1ps
module timer_slice_compare_capture_regs_bench;
	reg         clk, rst_n, reg_wr, reg_rd, compare_mode, capture_ext_01, timer_running, shadow_transfer;
	reg  [7:0]  reg_addr;
	reg  [31:0] reg_wdata;
	reg  [15:0] timer_count_value;
	reg  [3:0]  prescaler_value, k;
	reg  [2:0]  capture_event;
	wire [31:0] reg_rdata;
	wire [15:0] active_compare_value, timer_load_value;
	wire        timer_load, irq;
	integer     n_errors, checks_done;
	slice_cc_regs u_slice_cc_regs (
		.clk                  (clk),
		.rst_n                (rst_n),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_rdata            (reg_rdata),
		.compare_mode         (compare_mode),
		.capture_ext_01       (capture_ext_01),
		.timer_running        (timer_running),
		.timer_count_value    (timer_count_value),
		.prescaler_value      (prescaler_value),
		.shadow_transfer      (shadow_transfer),
		.capture_event        (capture_event),
		.active_compare_value (active_compare_value),
		.timer_load           (timer_load),
		.timer_load_value     (timer_load_value),
		.irq                  (irq)
	);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One register access; a read compares against v
	task acc(input w, input [7:0] a, input [31:0] v);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		if (!w)
			chk(reg_rdata, v);
	endtask
	// Mode levels plus one-cycle event pulses
	task ev(input s, input [2:0] c, input cm, input ext, input run);
		@(posedge clk);
		shadow_transfer <= s;
		capture_event <= c;
		compare_mode <= cm;
		capture_ext_01 <= ext;
		timer_running <= run;
		@(posedge clk);
		shadow_transfer <= 1'b0;
		capture_event <= 3'h0;
		#1;
	endtask
	task t_shadow;
		acc(1'b0, 8'h00, 32'h00000000);
		acc(1'b1, 8'h00, 32'hFFFFACE1);
		acc(1'b0, 8'h00, 32'h0000ACE1);
		acc(1'b1, 8'h14, 32'h00001234);
		chk({16'h0000, active_compare_value}, 32'h00000000);
		ev(1'b1, 3'h0, 1'b1, 1'b0, 1'b0);
		chk({16'h0000, active_compare_value}, 32'h0000ACE1);
		acc(1'b0, 8'h14, 32'h0000ACE1);
		ev(1'b0, 3'h0, 1'b0, 1'b1, 1'b0);
		acc(1'b0, 8'h00, 32'h00000000);
	endtask
	task t_timer;
		ev(1'b0, 3'h0, 1'b1, 1'b0, 1'b1);
		acc(1'b1, 8'h04, 32'h00005555);
		chk({31'h0, timer_load}, 32'h00000000);
		ev(1'b0, 3'h0, 1'b1, 1'b0, 1'b0);
		acc(1'b1, 8'h04, 32'hFFFF1234);
		chk({15'h0000, timer_load, timer_load_value}, 32'h00011234);
		acc(1'b0, 8'h04, 32'h0000BEEF);
	endtask
	task t_capture;
		for (k = 4'h1; k < 4'h4; k = k + 4'h1) begin
			@(posedge clk);
			timer_count_value <= {4{k}};
			prescaler_value <= k + 4'h4;
			ev(1'b0, 3'h1 << (k - 4'h1), 1'b0, 1'b0, 1'b0);
			acc(1'b0, 8'h04 + {2'b00, k, 2'b00}, {11'h000, 1'b1, k + 4'h4, {4{k}}});
			acc(1'b0, 8'h04 + {2'b00, k, 2'b00}, {11'h000, 1'b0, k + 4'h4, {4{k}}});
		end
		ev(1'b0, 3'h0, 1'b1, 1'b0, 1'b0);
		acc(1'b0, 8'h0C, 32'h00000000);
		ev(1'b0, 3'h4, 1'b1, 1'b0, 1'b0);
		ev(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
		acc(1'b0, 8'h10, 32'h00073333);
	endtask
	// Mask in the shadow event, then clear status by reading it
	task t_irq;
		acc(1'b1, 8'h1C, 32'h00000008);
		chk({31'h0, irq}, 32'h00000001);
		acc(1'b0, 8'h1C, 32'h00000008);
		acc(1'b0, 8'h18, 32'h0000000F);
		chk({31'h0, irq}, 32'h00000000);
		acc(1'b0, 8'h24, 32'h00000000);
	endtask
	task stop_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		{rst_n, reg_wr, reg_rd, capture_ext_01, timer_running, shadow_transfer} = 6'h00;
		{reg_addr, reg_wdata, prescaler_value, capture_event} = 47'h0;
		compare_mode = 1'b1;
		timer_count_value = 16'hBEEF;
		n_errors = 0;
		checks_done = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_shadow;
		t_timer;
		t_capture;
		t_irq;
		stop_test;
	end
endmodule
